/* File: ddrio_fifo.v */
// small synchronous fifo for captured word pairs
`timescale 1ns/100ps
module ddrio_fifo #(
	parameter W = 16,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire core_clk_i, // clock
	input wire rst_i, // async reset
	input wire in_valid_i, // write request
	output wire in_ready_o, // not full
	input wire [W-1:0] in_data_i, // write data
	output wire out_valid_o, // not empty
	input wire out_ready_i, // read accept
	output wire [W-1:0] out_data_o // head word
);
	reg [W-1:0] mem [0:DEPTH-1];
	reg [AW:0] wp_q;
	reg [AW:0] rp_q;
	wire [AW:0] cnt = wp_q - rp_q;
	wire wr = in_valid_i & in_ready_o;
	wire rd = out_valid_o & out_ready_i;
	// full when count reaches depth
	assign in_ready_o = (cnt != DEPTH[AW:0]);
	assign out_valid_o = (cnt != {(AW+1){1'b0}});
	assign out_data_o = mem[rp_q[AW-1:0]];
	// pointers
	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wp_q <= {(AW+1){1'b0}};
			rp_q <= {(AW+1){1'b0}};
		end else begin
			if (wr)
				wp_q <= wp_q + 1'b1;
			if (rd)
				rp_q <= rp_q + 1'b1;
		end
	end
	// storage, no reset needed for data
	always @(posedge core_clk_i) begin
		if (wr)
			mem[wp_q[AW-1:0]] <= in_data_i;
	end
endmodule // ddrio_fifo

/* File: ddrio_mem_model.sv */
// far-side memory model: strobe-framed word pairs and reference clock
`timescale 1ns/100ps
module ddrio_mem_model (
	output logic strobe_o = 1'b0, // strobe, still low between bursts
	output logic [7:0] dq_o = 8'h00, // data pins
	output logic ref_clk_o = 1'b0 // phase reference
);
	// same rate as the strobe, offset so no edge meets a core edge
	initial #3 forever #100 ref_clk_o = ~ref_clk_o;
	// edge-aligned data, as a memory sends it; centring is the device's job
	task automatic send(input logic [7:0] a, input logic [7:0] b);
		dq_o = a;
		strobe_o = 1'b1;
		#100;
		dq_o = b;
		strobe_o = 1'b0;
		#100;
		dq_o = ~b; // released bus shows no stale value
	endtask
endmodule // ddrio_mem_model

/* File: ddrio_pin_group.v */
// double-rate capture and launch logic for one strobe group of data pins
// Function
// - each pin element keeps six registers and one latch for both-edge transfer
// - input mode samples pin on strobe rising and falling edges
// - clock-high bit held so both bits appear on one edge
// - two fabric streams load two output registers on rising edge
// - pin shows first bit clock high, second bit clock low
// - bidirectional mode runs capture and launch paths together
// - bidirectional enable register on falling edge delays drive
// - driver enable is active low; user enable inverted first
// - every input to the element has optional local inversion
// - data group width code x4 keeps four lanes; x8, x16, x32 all enable every lane
// - strobe capture only for data pins; strobe only on strobe pin
// - strobe passes compensated delay into data valid window
// - delayed strobe is dedicated capture clock of data registers
// - per-side phase reference sets delay of its own side only
// - reference from clock pins or PLL 5 top, PLL 6 bottom
// - up to eighteen strobe pairs per edge
`timescale 1ns/100ps
`include "ddrio_regs.vh"
module ddrio_pin_group #(
	parameter DQ_W = `DDRIO_DQ_W,
	parameter DLY_W = `DDRIO_DLY_W,
	parameter SIDE = `DDRIO_SIDE_TOP,
	parameter GROUP_IDX = 0
) (
	input wire core_clk_i, // 40 mhz sample clock
	input wire rst_i, // async reset, high
	input wire [2:0] mode_i, // one-hot in/out/bidir
	input wire [1:0] bus_width_i, // group width code
	input wire [DQ_W+4:0] inv_i, // per-input inversion selects
	input wire io_clk_i, // i/o clock from outside
	input wire ref_clk_i, // phase reference clock
	input wire [2:0] ref_src_i, // 0 = clock pin, else pll number
	input wire strobe_i, // strobe pin level
	input wire [DQ_W-1:0] dq_i, // data pin levels
	output wire [DQ_W-1:0] dq_o, // data pin drive level
	output wire [DQ_W-1:0] dq_oe_o, // high while driving
	input wire [DQ_W-1:0] tx_a_i, // first-bit stream
	input wire [DQ_W-1:0] tx_b_i, // second-bit stream
	input wire tx_oe_i, // user enable, active high
	output wire [2*DQ_W-1:0] rx_data_o, // {falling, rising} bits
	output wire rx_valid_o, // fifo not empty
	input wire rx_ready_i, // fabric accepts word
	output wire rx_overflow_o, // capture lost, fifo full
	output wire [DLY_W-1:0] strobe_dly_o, // current delay in samples
	output wire ref_ok_o // reference source legal
);
	// two-flop synchronisers for every pin-side input
	reg [DQ_W+2:0] s1_q;
	reg [DQ_W+2:0] s2_q;
	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s1_q <= {(DQ_W+3){1'b0}};
			s2_q <= {(DQ_W+3){1'b0}};
		end else begin
			s1_q <= {ref_clk_i, io_clk_i, strobe_i, dq_i};
			s2_q <= s1_q;
		end
	end
	// local inversion applied inside the element
	wire [DQ_W-1:0] dq_s = s2_q[DQ_W-1:0] ^ inv_i[DQ_W-1:0];
	wire strobe_s = s2_q[DQ_W] ^ inv_i[DQ_W];
	wire ioclk_s = s2_q[DQ_W+1] ^ inv_i[DQ_W+1];
	wire refclk_s = s2_q[DQ_W+2];
	wire oe_req = tx_oe_i ^ inv_i[DQ_W+2];
	wire [DQ_W-1:0] txa_s = tx_a_i ^ {DQ_W{inv_i[DQ_W+3]}};
	wire [DQ_W-1:0] txb_s = tx_b_i ^ {DQ_W{inv_i[DQ_W+4]}};

	// edge finders on the sampled clocks
	reg strobe_p_q;
	reg ioclk_p_q;
	reg refclk_p_q;
	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			strobe_p_q <= 1'b0;
			ioclk_p_q <= 1'b0;
			refclk_p_q <= 1'b0;
		end else begin
			strobe_p_q <= strobe_s;
			ioclk_p_q <= ioclk_s;
			refclk_p_q <= refclk_s;
		end
	end
	wire io_rise = ioclk_s & ~ioclk_p_q;
	wire io_fall = ~ioclk_s & ioclk_p_q;
	wire ref_rise = refclk_s & ~refclk_p_q;

	// legal reference: clock pin or the one pll of this side
	wire [2:0] side_pll = (SIDE == `DDRIO_SIDE_BOT) ? `DDRIO_PLL_BOT : `DDRIO_PLL_TOP;
	assign ref_ok_o = (ref_src_i == 3'h0) | (ref_src_i == side_pll);

	// phase reference: measure period of the side's reference clock
	// limitation: reference must match strobe frequency, it is not checked
	reg [DLY_W-1:0] per_cnt_q;
	reg [DLY_W-1:0] quarter_q;
	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			per_cnt_q <= {DLY_W{1'b0}};
			quarter_q <= {{(DLY_W-1){1'b0}}, 1'b1};
		end else if (ref_rise) begin
			per_cnt_q <= {{(DLY_W-1){1'b0}}, 1'b1};
			if (ref_ok_o && per_cnt_q[DLY_W-1:2] != {(DLY_W-2){1'b0}})
				quarter_q <= {2'b00, per_cnt_q[DLY_W-1:2]};
		end else if (per_cnt_q != {DLY_W{1'b1}}) begin
			per_cnt_q <= per_cnt_q + 1'b1;
		end
	end
	assign strobe_dly_o = quarter_q;

	// compensated delay line on the strobe, one tap per sample clock
	reg [(1<<DLY_W)-1:0] dly_line_q;
	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i)
			dly_line_q <= {(1<<DLY_W){1'b0}};
		else
			dly_line_q <= {dly_line_q[(1<<DLY_W)-2:0], strobe_s};
	end
	wire dqs_dly = dly_line_q[quarter_q - 1'b1];
	reg dqs_dly_p_q;
	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i)
			dqs_dly_p_q <= 1'b0;
		else
			dqs_dly_p_q <= dqs_dly;
	end
	// local strobe net, never the i/o clock, clocks data capture
	wire cap_rise = dqs_dly & ~dqs_dly_p_q;
	wire cap_fall = ~dqs_dly & dqs_dly_p_q;
	// the pin data is not delayed, so the delayed strobe lands mid-eye
	wire [DQ_W-1:0] dq_cap;

	// active lane mask from the group width
	reg [DQ_W-1:0] lane_mask;
	always @* begin
		case (bus_width_i)
			`DDRIO_BUS_X4: lane_mask = {{(DQ_W-4){1'b0}}, 4'hf};
			default: lane_mask = {DQ_W{1'b1}};
		endcase
	end
	assign dq_cap = dq_s & lane_mask;

	wire cap_en = mode_i[0] | mode_i[2];
	wire tx_en = mode_i[1] | mode_i[2];

	// per-pin element: two input regs, latch, two output regs, two oe regs
	reg [DQ_W-1:0] in_hi_q;
	reg [DQ_W-1:0] in_lo_q;
	reg [DQ_W-1:0] latch_q;
	reg [DQ_W-1:0] out_a_q;
	reg [DQ_W-1:0] out_b_q;
	reg [DQ_W-1:0] oe_n_q;
	reg [DQ_W-1:0] oe_neg_n_q;
	reg pair_q;
	genvar g;
	generate
		for (g = 0; g < DQ_W; g = g + 1) begin : g_pin
			always @(posedge core_clk_i or posedge rst_i) begin
				if (rst_i) begin
					in_hi_q[g] <= 1'b0;
					in_lo_q[g] <= 1'b0;
					latch_q[g] <= 1'b0;
					out_a_q[g] <= 1'b0;
					out_b_q[g] <= 1'b0;
					oe_n_q[g] <= 1'b1;
					oe_neg_n_q[g] <= 1'b1;
				end else begin
					if (cap_en && cap_rise)
						in_hi_q[g] <= dq_cap[g];
					if (cap_en && cap_fall)
						in_lo_q[g] <= dq_cap[g];
					// latch transparent while strobe high, holds during low
					if (dqs_dly)
						latch_q[g] <= in_hi_q[g];
					if (tx_en && io_rise) begin
						out_a_q[g] <= txa_s[g];
						out_b_q[g] <= txb_s[g];
						oe_n_q[g] <= ~(oe_req & lane_mask[g]);
					end
					// bidir: enable waits for falling edge to meet memory timing
					if (io_fall)
						oe_neg_n_q[g] <= oe_n_q[g];
				end
			end
			// clock picks first register high, second low
			assign dq_o[g] = ioclk_s ? out_a_q[g] : out_b_q[g];
			// output path alone uses the rising-edge oe register
			// lane mask gates the driver at once, so a narrowed group never
			// waits up to an io clock period plus a phase with stale upper lanes
			assign dq_oe_o[g] = tx_en & lane_mask[g] &
				~(mode_i[2] ? oe_neg_n_q[g] : oe_n_q[g]);
		end
	endgenerate

	// both bits aligned on the falling strobe edge, then into the fifo
	reg push_q;
	reg [2*DQ_W-1:0] push_data_q;
	reg ovf_q;
	wire fifo_ready;
	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			push_q <= 1'b0;
			push_data_q <= {(2*DQ_W){1'b0}};
			ovf_q <= 1'b0;
			pair_q <= 1'b0;
		end else begin
			pair_q <= cap_en & cap_fall;
			push_q <= 1'b0;
			// word lands a cycle after the falling capture updates in_lo
			if (pair_q) begin
				push_q <= 1'b1;
				push_data_q <= {in_lo_q, latch_q};
			end
			// link cannot stall, so a full fifo drops and flags it;
			// judged when the push meets the fifo, not a cycle earlier
			if (push_q && !fifo_ready)
				ovf_q <= 1'b1;
		end
	end
	assign rx_overflow_o = ovf_q;

	ddrio_fifo #(
		.W(2*DQ_W),
		.DEPTH(`DDRIO_FIFO_DEPTH),
		.AW(`DDRIO_FIFO_AW)
	) u_fifo (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.in_valid_i(push_q),
		.in_ready_o(fifo_ready),
		.in_data_i(push_data_q),
		.out_valid_o(rx_valid_o),
		.out_ready_i(rx_ready_i),
		.out_data_o(rx_data_o)
	);
	// group index is kept for placement; up to eighteen groups per edge
	wire unused_idx = (GROUP_IDX < `DDRIO_STROBE_PAIRS);
endmodule // ddrio_pin_group

/* File: ddrio_pin_group_monitor.sv */
// assertion checker for the double-rate pin group
`timescale 1ns/100ps
module ddrio_pg_monitor #(
	parameter DQ_W = 8,
	parameter DLY_W = 8,
	parameter SIDE = 0
) (
	input wire core_clk_i, // clock
	input wire rst_i, // reset
	input wire [2:0] mode_i, // mode
	input wire [1:0] bus_width_i, // width
	input wire [DQ_W+4:0] inv_i, // inversion
	input wire [2:0] ref_src_i, // ref source
	input wire tx_oe_i, // user enable
	input wire [DQ_W-1:0] dq_oe_o, // drive
	input wire [2*DQ_W-1:0] rx_data_o, // pair
	input wire rx_valid_o, // valid
	input wire rx_ready_i, // ready
	input wire rx_overflow_o, // lost
	input wire [DLY_W-1:0] strobe_dly_o, // delay
	input wire ref_ok_o // legal ref
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	logic [4:0] off_q;
	// cycles with the effective enable low; covers the io clock phase wait
	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) off_q <= 5'h00;
		else if (tx_oe_i ^ inv_i[DQ_W+2]) off_q <= 5'h00;
		else if (off_q != 5'h1f) off_q <= off_q + 5'h01;
	end
	a_input_no_drive: assert property ((mode_i == 3'h1) [*4] |-> dq_oe_o == '0)
		else $error("driver on in input mode");
	a_oe_off_idle: assert property (off_q >= 5'h10 |-> dq_oe_o == '0)
		else $error("driver on with enable off");
	a_pair_stands: assert property (rx_valid_o && !rx_ready_i |=>
		rx_valid_o && $stable(rx_data_o)) else $error("pair changed before accept");
	a_ovf_sticky: assert property (rx_overflow_o |=> rx_overflow_o)
		else $error("overflow flag dropped");
	a_ovf_when_full: assert property ($rose(rx_overflow_o) |-> $past(rx_valid_o))
		else $error("overflow with empty buffer");
	a_ref_src_legal: assert property (ref_ok_o == (ref_src_i == 3'h0 ||
		ref_src_i == (SIDE ? 3'h6 : 3'h5))) else $error("reference legality wrong");
	a_delay_nonzero: assert property (strobe_dly_o != '0)
		else $error("strobe delay zero");
	a_x4_upper_idle: assert property ((bus_width_i == 2'h0) [*8] |->
		dq_oe_o[DQ_W-1:4] == '0) else $error("upper lanes driven in x4");
	cover property (rx_valid_o && rx_ready_i);
	cover property ($rose(rx_overflow_o));
	cover property ($rose(dq_oe_o[0]));
	cover property (mode_i == 3'h4 && rx_valid_o && rx_ready_i);
endmodule // ddrio_pg_monitor
bind ddrio_pin_group ddrio_pg_monitor #(.DQ_W(DQ_W), .DLY_W(DLY_W), .SIDE(SIDE)) ddrio_pg_monitor_i (
	.core_clk_i(core_clk_i), .rst_i(rst_i), .mode_i(mode_i), .bus_width_i(bus_width_i),
	.inv_i(inv_i), .ref_src_i(ref_src_i), .tx_oe_i(tx_oe_i), .dq_oe_o(dq_oe_o),
	.rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i),
	.rx_overflow_o(rx_overflow_o), .strobe_dly_o(strobe_dly_o), .ref_ok_o(ref_ok_o));

/* File: ddrio_pin_group_tb_top.sv */
// self-checking bench for the double-rate pin group
`timescale 1ns/100ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin mismatches++; \
	$display("ERROR %s expected %h seen %h", nm, e, g); end end
module ddrio_pin_group_tb_top;
	logic core_clk_i = 1'b0, rst_i = 1'b1, io_clk = 1'b0, tx_oe = 1'b0, rdy = 1'b0;
	logic [2:0] mode = 3'h1, ref_src = 3'h5;
	logic [1:0] bus_w = 2'h1;
	logic [12:0] inv = 13'h0000;
	logic [7:0] tx_a = 8'h5a, tx_b = 8'ha5;
	wire strobe, ref_clk, rx_valid, rx_ovf, ref_ok;
	wire [7:0] mem_dq, dq_o, dq_oe, pin, dly;
	wire [15:0] rx_data;
	int mismatches = 0, check_count = 0, cyc = 0, n;
	assign pin = (dq_oe & dq_o) | (~dq_oe & mem_dq); // shared pin level
	always #12.5 core_clk_i = ~core_clk_i;
	// launch clock, phase unrelated to the core clock
	initial #37 forever #100 io_clk = ~io_clk;
	ddrio_pin_group ddrio_pin_group_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .mode_i(mode),
		.bus_width_i(bus_w), .inv_i(inv), .io_clk_i(io_clk), .ref_clk_i(ref_clk),
		.ref_src_i(ref_src), .strobe_i(strobe), .dq_i(pin), .dq_o(dq_o), .dq_oe_o(dq_oe),
		.tx_a_i(tx_a), .tx_b_i(tx_b), .tx_oe_i(tx_oe), .rx_data_o(rx_data),
		.rx_valid_o(rx_valid), .rx_ready_i(rdy), .rx_overflow_o(rx_ovf),
		.strobe_dly_o(dly), .ref_ok_o(ref_ok));
	ddrio_mem_model ddrio_mem_model_i (.strobe_o(strobe), .dq_o(mem_dq), .ref_clk_o(ref_clk));
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// one accepted pair, then release of ready
	task automatic take(input logic [15:0] e);
		`CHK("pair", {1'b1, e}, {rx_valid, rx_data})
		rdy = 1'b1;
		@(negedge core_clk_i);
		rdy = 1'b0;
		@(negedge core_clk_i);
	endtask
	task automatic t_ref();
		`CHK("delay", 8'h02, dly)
		for (int s = 0; s < 8; s++) begin
			ref_src = s[2:0];
			@(negedge core_clk_i);
			`CHK("ref_ok", (s == 0 || s == 5), ref_ok)
		end
		ref_src = 3'h5;
		$display("reference test done");
	endtask
	// ten back-to-back pairs into an eight-word buffer held stalled
	task automatic t_capture();
		for (int i = 0; i < 10; i++) ddrio_mem_model_i.send(8'h10 + i[7:0], 8'hc0 + i[7:0]);
		repeat (8) @(negedge core_clk_i);
		`CHK("overflow", 1'b1, rx_ovf)
		for (int i = 0; i < 8; i++) take({8'hc0 + i[7:0], 8'h10 + i[7:0]});
		`CHK("empty", 1'b0, rx_valid)
		inv[7:0] = 8'hff;
		ddrio_mem_model_i.send(8'h3c, 8'h81);
		repeat (8) @(negedge core_clk_i);
		take(16'h7ec3);
		inv[7:0] = 8'h00;
		$display("capture test done");
	endtask
	task automatic t_launch(input logic [2:0] m, input logic [7:0] at_on);
		mode = m;
		tx_oe = 1'b1;
		for (n = 0; n < 40 && dq_oe[0] !== 1'b1; n++) @(negedge core_clk_i);
		`CHK("drive_on", {8'hff, at_on}, {dq_oe, dq_o})
		for (n = 0; n < 8 && dq_o === at_on; n++) @(negedge core_clk_i);
		`CHK("second_bit", ~at_on, dq_o)
		bus_w = 2'h0;
		repeat (16) @(negedge core_clk_i);
		`CHK("x4_lanes", 8'h0f, dq_oe)
		bus_w = 2'h1;
		tx_oe = 1'b0;
		repeat (16) @(negedge core_clk_i);
		`CHK("drive_off", 8'h00, dq_oe)
		inv[10] = 1'b1;
		repeat (16) @(negedge core_clk_i);
		`CHK("oe_invert", 8'hff, dq_oe)
		inv[10] = 1'b0;
		repeat (16) @(negedge core_clk_i);
		$display("launch test done");
	endtask
	// capture still works while the pin is bidirectional
	task automatic t_bidir();
		ddrio_mem_model_i.send(8'h69, 8'h96);
		repeat (8) @(negedge core_clk_i);
		take(16'h9669);
		$display("bidir test done");
	endtask
	always @(posedge core_clk_i) begin
		cyc++;
		if (cyc == 4000) begin
			mismatches++;
			finish_test();
		end
	end
	initial begin
		repeat (5) @(negedge core_clk_i);
		rst_i = 1'b0;
		repeat (60) @(negedge core_clk_i);
		t_ref();
		t_capture();
		t_launch(3'h2, 8'h5a);
		t_launch(3'h4, 8'ha5);
		t_bidir();
		finish_test();
	end
endmodule // ddrio_pin_group_tb_top

/* File: ddrio_regs.vh */
// constants for the double-rate pin capture/launch block
`ifndef DDRIO_REGS_VH
`define DDRIO_REGS_VH
`define DDRIO_CLK_MHZ 40
`define DDRIO_DQ_W 8
`define DDRIO_FIFO_DEPTH 8
`define DDRIO_FIFO_AW 3
`define DDRIO_MODE_IN 3'b001
`define DDRIO_MODE_OUT 3'b010
`define DDRIO_MODE_BIDIR 3'b100
`define DDRIO_BUS_X4 2'h0
`define DDRIO_BUS_X8 2'h1
`define DDRIO_BUS_X16 2'h2
`define DDRIO_BUS_X32 2'h3
`define DDRIO_STROBE_PAIRS 18
`define DDRIO_SIDE_TOP 1'b0
`define DDRIO_SIDE_BOT 1'b1
`define DDRIO_PLL_TOP 3'h5
`define DDRIO_PLL_BOT 3'h6
`define DDRIO_DLY_W 8
`endif
